//--- verilog/sfcp_serial_flash_cmd_protect.sv
/*
  Serial flash command front end: chip-select framing, pin roles, length
  checks, write latch, block protection and erase/program request issue.
  Assumes the host holds chip select high while the core reset is applied
  and waits three core clocks after chip select falls before clocking.
*/
`timescale 1ns/100ps
`default_nettype none
module sfcp_serial_flash_cmd_protect #(
  parameter logic [7:0] ID_MAKER = 8'h5A, // Arbitrary value.
  parameter logic [7:0] ID_TYPE  = 8'h3C, // Arbitrary value.
  parameter logic [7:0] ID_CAP   = 8'h15, // Arbitrary value.
  parameter logic [7:0] ID_SIG   = 8'h24  // Arbitrary value.
) (
  input  wire logic          ref_clk_in,
  input  wire logic          srst_in,
  input  wire logic          clk_en_in,
  input  wire logic          sclk_in,
  input  wire logic          cs_n_in,
  input  wire logic          serial_in_io0_in,
  output logic               serial_in_io0_out,
  output logic               serial_in_io0_oe_out,
  input  wire logic          serial_out_io1_in,
  output logic               serial_out_io1_out,
  output logic               serial_out_io1_oe_out,
  input  wire logic          wp_n_in,
  input  wire logic          busy_in,
  output logic               write_enable_latch_out,
  output logic [3:0]         block_protect_field_out,
  output logic               status_write_lock_bit_out,
  output logic               deep_sleep_out,
  output logic               erase_req_out,
  output logic               prog_req_out,
  output var sfcp_pkg::sfcp_req_t req_out,
  output logic               cmd_drop_out
);
  // ==========================================================================
  // Core-side state
  logic                 lk_rst_q;
  logic                 cs_meta_q, cs_sync_q, cs_prev_q;
  logic                 tgl_meta_q, tgl_sync_q, tgl_mark_q;
  logic                 wp_meta_q, wp_sync_q;
  logic                 wel_q, lock_q, deep_q;
  logic [3:0]           bp_q;
  sfcp_pkg::sfcp_snap_t snap_q;
  // ==========================================================================
  // Link-side state
  logic [11:0]          cnt_q, len_q, rel;
  logic [31:0]          sh_q;
  logic [7:0]           op_q, op_next, rd_byte;
  logic [20:0]          addr_q;
  logic                 tgl_q, accept, is_read, dual, rd_on;
  logic [11:0]          start;
  logic [9:0]           byte_idx;
  sfcp_pkg::sfcp_link_t mode_q;

  // Serial-out pin is only driven by us, never sampled.
  logic unused_io1;
  assign unused_io1 = serial_out_io1_in;

  // ==========================================================================
  // Link domain: framing and shift-in on rising clock edges
  assign op_next = {sh_q[6:0], serial_in_io0_in};
  always_comb
  begin
    accept = sfcp_pkg::op_known(op_next);
    if (snap_q.deep && op_next != sfcp_pkg::OP_SIG)
    begin
      accept = 1'b0;
    end
    if (snap_q.busy && sfcp_pkg::op_array(op_next))
    begin
      accept = 1'b0;
    end
  end

  // Chip select high clears the frame asynchronously, since the host's
  // clock is not guaranteed to run between frames.
  always_ff @(posedge sclk_in or posedge cs_n_in)
  begin
    if (cs_n_in)
    begin
      cnt_q  <= '0;
      mode_q <= sfcp_pkg::LK_CMD;
    end
    else
    begin
      if (cnt_q != sfcp_pkg::CNT_MAX)
      begin
        cnt_q <= cnt_q + 12'h001;
      end
      if (cnt_q == sfcp_pkg::LEN_OP - 12'h001)
      begin
        mode_q <= accept ? sfcp_pkg::LK_ACTIVE : sfcp_pkg::LK_STANDBY;
      end
    end
  end

  always_ff @(posedge sclk_in or posedge lk_rst_q)
  begin
    if (lk_rst_q)
    begin
      sh_q   <= '0;
      len_q  <= '0;
      tgl_q  <= 1'b0;
      op_q   <= '0;
      addr_q <= '0;
    end
    else
    begin
      sh_q  <= {sh_q[30:0], serial_in_io0_in};
      len_q <= (cnt_q == sfcp_pkg::CNT_MAX) ? cnt_q : cnt_q + 12'h001;
      if (cnt_q == '0)
      begin
        tgl_q <= ~tgl_q;
      end
      if (cnt_q == sfcp_pkg::LEN_OP - 12'h001)
      begin
        op_q <= op_next;
      end
      if (cnt_q == sfcp_pkg::LEN_ADDR - 12'h001)
      begin
        addr_q <= {sh_q[19:0], serial_in_io0_in};
      end
    end
  end

  // ==========================================================================
  // Link domain: output launch on falling clock edges
  always_comb
  begin
    is_read = 1'b1;
    dual    = (op_q == sfcp_pkg::OP_DUAL);
    unique case (op_q)
      sfcp_pkg::OP_STAT_RD, sfcp_pkg::OP_IDENT: start = sfcp_pkg::LEN_OP;
      sfcp_pkg::OP_SIG, sfcp_pkg::OP_MAKER, sfcp_pkg::OP_READ:
        start = sfcp_pkg::LEN_ADDR;
      sfcp_pkg::OP_FAST, sfcp_pkg::OP_DUAL, sfcp_pkg::OP_PARAM:
        start = sfcp_pkg::LEN_DUMMY;
      default:
      begin
        start   = sfcp_pkg::CNT_MAX;
        is_read = 1'b0;
      end
    endcase
    rd_on    = (mode_q == sfcp_pkg::LK_ACTIVE) && is_read
               && (cnt_q >= start);
    rel      = cnt_q - start;
    byte_idx = dual ? rel[11:2] : {1'b0, rel[11:3]};
    unique case (op_q)
      sfcp_pkg::OP_STAT_RD: rd_byte = snap_q.stat;
      sfcp_pkg::OP_SIG:     rd_byte = ID_SIG;
      sfcp_pkg::OP_MAKER:
        rd_byte = (byte_idx[0] ^ addr_q[0]) ? ID_TYPE : ID_MAKER;
      sfcp_pkg::OP_IDENT:
      begin
        unique case (byte_idx % sfcp_pkg::ID_LEN)
          10'h000: rd_byte = ID_MAKER;
          10'h001: rd_byte = ID_TYPE;
          default: rd_byte = ID_CAP;
        endcase
      end
      default:              rd_byte = sfcp_pkg::FILL_BYTE;
    endcase
  end

  always_ff @(negedge sclk_in or posedge cs_n_in)
  begin
    if (cs_n_in)
    begin
      serial_in_io0_out     <= 1'b0;
      serial_in_io0_oe_out  <= 1'b0;
      serial_out_io1_out    <= 1'b0;
      serial_out_io1_oe_out <= 1'b0;
    end
    else
    begin
      serial_out_io1_oe_out <= rd_on;
      serial_in_io0_oe_out  <= rd_on && dual;
      if (dual)
      begin
        serial_out_io1_out <= rd_byte[{~rel[1:0], 1'b1}];
        serial_in_io0_out  <= rd_byte[{~rel[1:0], 1'b0}];
      end
      else
      begin
        serial_out_io1_out <= rd_byte[3'h7 - rel[2:0]];
        serial_in_io0_out  <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Core domain: crossings
  always_ff @(posedge ref_clk_in)
  begin
    lk_rst_q <= srst_in;
    if (srst_in)
    begin
      cs_meta_q  <= 1'b1;
      cs_sync_q  <= 1'b1;
      cs_prev_q  <= 1'b1;
      tgl_meta_q <= 1'b0;
      tgl_sync_q <= 1'b0;
      tgl_mark_q <= 1'b0;
      wp_meta_q  <= 1'b1;
      wp_sync_q  <= 1'b1;
    end
    else if (clk_en_in)
    begin
      cs_meta_q  <= cs_n_in;
      cs_sync_q  <= cs_meta_q;
      cs_prev_q  <= cs_sync_q;
      tgl_meta_q <= tgl_q;
      tgl_sync_q <= tgl_meta_q;
      wp_meta_q  <= wp_n_in;
      wp_sync_q  <= wp_meta_q;
      if (!cs_sync_q && cs_prev_q)
      begin
        tgl_mark_q <= tgl_sync_q;
      end
    end
  end

  // The snapshot only moves while deselected, so the link reads a word
  // that is frozen for the whole frame; chip select is the handshake.
  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      snap_q <= '0;
    end
    else if (clk_en_in && cs_sync_q)
    begin
      snap_q <= '{deep: deep_q, busy: busy_in,
                  stat: '{lock: lock_q, rsvd: 1'b0, bp: bp_q, write_enable_latch: wel_q,
                          wip: busy_in}};
    end
  end

  // ==========================================================================
  // Core domain: command completion at chip select release
  logic       frame_end, byte_ok, len_cmd, len_stat, len_addr, blk_prot;
  logic       do_set, do_clr, do_stat, do_erase, do_prog, do_sleep, do_wake;
  logic       do_drop;
  logic [8:0] nbytes;
  sfcp_pkg::sfcp_erase_t kind;

  assign frame_end = cs_sync_q && !cs_prev_q && (tgl_sync_q != tgl_mark_q)
                     && (len_q >= sfcp_pkg::LEN_OP);
  assign byte_ok  = (len_q[2:0] == 3'h0);
  assign len_cmd  = (len_q == sfcp_pkg::LEN_OP);
  assign len_stat = (len_q == sfcp_pkg::LEN_STAT);
  assign len_addr = (len_q == sfcp_pkg::LEN_ADDR);
  assign blk_prot = sfcp_pkg::prot_hit(bp_q, addr_q[20:16]);
  assign nbytes   = (len_q[11:3] - 9'h004 > sfcp_pkg::PAGE_MAX)
                    ? sfcp_pkg::PAGE_MAX : len_q[11:3] - 9'h004;

  always_comb
  begin
    {do_set, do_clr, do_stat, do_erase, do_prog, do_sleep, do_wake} = '0;
    do_drop = 1'b0;
    kind    = sfcp_pkg::ERS_SECT;
    if (frame_end && deep_q)
    begin
      do_wake = (op_q == sfcp_pkg::OP_SIG);
    end
    else if (frame_end && !(busy_in && sfcp_pkg::op_array(op_q)))
    begin
      unique case (op_q)
        sfcp_pkg::OP_SET_WEL: do_set   = len_cmd;
        sfcp_pkg::OP_CLR_WEL: do_clr   = len_cmd;
        sfcp_pkg::OP_SLEEP:   do_sleep = len_cmd;
        sfcp_pkg::OP_STAT_WR: do_stat  = len_stat && wel_q;
        sfcp_pkg::OP_SECT, sfcp_pkg::OP_HALF, sfcp_pkg::OP_BLK:
        begin
          do_erase = len_addr && wel_q && !blk_prot;
          do_drop  = len_addr && wel_q && blk_prot;
          kind     = (op_q == sfcp_pkg::OP_SECT) ? sfcp_pkg::ERS_SECT
                   : (op_q == sfcp_pkg::OP_HALF) ? sfcp_pkg::ERS_HALF
                   : sfcp_pkg::ERS_BLK;
        end
        sfcp_pkg::OP_CHIP_A, sfcp_pkg::OP_CHIP_B:
        begin
          do_erase = len_cmd && wel_q && (bp_q == 4'h0);
          do_drop  = len_cmd && wel_q && (bp_q != 4'h0);
          kind     = sfcp_pkg::ERS_CHIP;
        end
        sfcp_pkg::OP_PAGE:
        begin
          do_prog = byte_ok && (len_q > sfcp_pkg::LEN_ADDR) && wel_q
                    && !blk_prot;
          do_drop = byte_ok && (len_q > sfcp_pkg::LEN_ADDR) && wel_q
                    && blk_prot;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      wel_q  <= 1'b0;
      bp_q   <= '0;
      lock_q <= 1'b0;
      deep_q <= 1'b0;
    end
    else if (clk_en_in)
    begin
      if (do_set)
      begin
        wel_q <= 1'b1;
      end
      else if (do_clr || do_stat || do_erase || do_prog || do_drop)
      begin
        wel_q <= 1'b0;
      end
      if (do_stat && wp_sync_q)
      begin
        bp_q   <= sh_q[5:2];
        lock_q <= sh_q[7];
      end
      if (do_sleep)
      begin
        deep_q <= 1'b1;
      end
      else if (do_wake)
      begin
        deep_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      erase_req_out <= 1'b0;
      prog_req_out  <= 1'b0;
      cmd_drop_out  <= 1'b0;
      req_out       <= '0;
    end
    else if (clk_en_in)
    begin
      erase_req_out <= do_erase;
      prog_req_out  <= do_prog;
      cmd_drop_out  <= do_drop;
      if (do_erase || do_prog)
      begin
        req_out.kind   <= kind;
        req_out.addr   <= addr_q;
        req_out.nbytes <= do_prog ? nbytes : 9'h000;
        req_out.sector <= addr_q[20:sfcp_pkg::SECT_LSB];
        req_out.half   <= addr_q[20:sfcp_pkg::HALF_LSB];
        req_out.block  <= addr_q[20:sfcp_pkg::BLK_LSB];
      end
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      write_enable_latch_out    <= 1'b0;
      block_protect_field_out   <= '0;
      status_write_lock_bit_out <= 1'b0;
      deep_sleep_out            <= 1'b0;
    end
    else if (clk_en_in)
    begin
      write_enable_latch_out    <= wel_q;
      block_protect_field_out   <= bp_q;
      status_write_lock_bit_out <= lock_q;
      deep_sleep_out            <= deep_q;
    end
  end
endmodule
`default_nettype wire

//--- common/sfcp_pkg.sv
/*
  Constants, types and the block-protect decoder shared by the serial
  flash command front end. Assumes a single SystemVerilog compile unit.
*/
package sfcp_pkg;
  // ==========================================================================
  // Command codes
  localparam logic [7:0] OP_SET_WEL = 8'h06;
  localparam logic [7:0] OP_CLR_WEL = 8'h04;
  localparam logic [7:0] OP_STAT_WR = 8'h01;
  localparam logic [7:0] OP_STAT_RD = 8'h05;
  localparam logic [7:0] OP_IDENT   = 8'h9F;
  localparam logic [7:0] OP_SIG     = 8'hAB;
  localparam logic [7:0] OP_MAKER   = 8'h90;
  localparam logic [7:0] OP_READ    = 8'h03;
  localparam logic [7:0] OP_FAST    = 8'h0B;
  localparam logic [7:0] OP_DUAL    = 8'h3B;
  localparam logic [7:0] OP_PARAM   = 8'h5A;
  localparam logic [7:0] OP_SECT    = 8'h20;
  localparam logic [7:0] OP_HALF    = 8'h52;
  localparam logic [7:0] OP_BLK     = 8'hD8;
  localparam logic [7:0] OP_CHIP_A  = 8'h60;
  localparam logic [7:0] OP_CHIP_B  = 8'hC7;
  localparam logic [7:0] OP_PAGE    = 8'h02;
  localparam logic [7:0] OP_SLEEP   = 8'hB9;
  localparam logic [7:0] OP_FACT    = 8'h41;
  localparam logic [7:0] OP_RST_EN  = 8'h66;
  localparam logic [7:0] OP_RST     = 8'h99;
  // ==========================================================================
  // Frame lengths in clock edges and field positions
  localparam logic [11:0] LEN_OP     = 12'h008;
  localparam logic [11:0] LEN_STAT   = 12'h010;
  localparam logic [11:0] LEN_ADDR   = 12'h020;
  localparam logic [11:0] LEN_DUMMY  = 12'h028;
  localparam logic [11:0] CNT_MAX    = 12'hFFF;
  localparam logic [8:0]  PAGE_MAX   = 9'h100;
  localparam logic [9:0]  ID_LEN     = 10'h003;
  localparam logic [7:0]  FILL_BYTE  = 8'hFF;
  localparam int          ADDR_W     = 21;
  localparam int          SECT_LSB   = 12;
  localparam int          HALF_LSB   = 15;
  localparam int          BLK_LSB    = 16;
  // ==========================================================================
  // Protect table: block range [lo, hi) per field value, 15 down to 0
  localparam logic [15:0][5:0] PROT_LO = {6'h00, 6'h00, 6'h00, 6'h00,
    6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00, 6'h10, 6'h18, 6'h1C, 6'h1E,
    6'h1F, 6'h20};
  localparam logic [15:0][5:0] PROT_HI = {6'h20, 6'h1F, 6'h1E, 6'h1C,
    6'h18, 6'h10, 6'h20, 6'h20, 6'h20, 6'h20, 6'h20, 6'h20, 6'h20, 6'h20,
    6'h20, 6'h20};
  // ==========================================================================
  // Types
  typedef enum logic [1:0] {ERS_SECT, ERS_HALF, ERS_BLK, ERS_CHIP}
    sfcp_erase_t;
  typedef enum logic [1:0] {LK_CMD, LK_ACTIVE, LK_STANDBY} sfcp_link_t;
  typedef struct packed {
    logic       lock;
    logic       rsvd;
    logic [3:0] bp;
    logic       write_enable_latch;
    logic       wip;
  } sfcp_stat_t;
  typedef struct packed {
    logic       deep;
    logic       busy;
    sfcp_stat_t stat;
  } sfcp_snap_t;
  typedef struct packed {
    sfcp_erase_t         kind;
    logic [ADDR_W-1:0]   addr;
    logic [8:0]          nbytes;
    logic [8:0]          sector;
    logic [5:0]          half;
    logic [4:0]          block;
  } sfcp_req_t;
  // ==========================================================================
  // Returns one when the 64KB block lies inside the protected range.
  function automatic logic prot_hit(input logic [3:0] bp,
                                    input logic [4:0] blk);
    prot_hit = ({1'b0, blk} >= PROT_LO[bp]) && ({1'b0, blk} < PROT_HI[bp]);
  endfunction
  function automatic logic op_known(input logic [7:0] op);
    op_known = op inside {OP_SET_WEL, OP_CLR_WEL, OP_STAT_WR, OP_STAT_RD,
      OP_IDENT, OP_SIG, OP_MAKER, OP_READ, OP_FAST, OP_DUAL, OP_PARAM,
      OP_SECT, OP_HALF, OP_BLK, OP_CHIP_A, OP_CHIP_B, OP_PAGE, OP_SLEEP,
      OP_FACT, OP_RST_EN, OP_RST};
  endfunction
  function automatic logic op_array(input logic [7:0] op);
    op_array = op inside {OP_READ, OP_FAST, OP_DUAL, OP_PARAM, OP_IDENT,
      OP_SECT, OP_HALF, OP_BLK, OP_CHIP_A, OP_CHIP_B, OP_PAGE, OP_STAT_WR};
  endfunction
endpackage

//--- bench/sfcp_props.sv
/*
  Port checker for the serial flash command front end.
  Assumes it is bound to the design top module; all ports are inputs.
*/
`timescale 1ns/100ps
`default_nettype none
module sfcp_props (
  input wire logic                ref_clk_in,
  input wire logic                srst_in,
  input wire logic                cs_n_in,
  input wire logic                wp_n_in,
  input wire logic                serial_in_io0_oe_out,
  input wire logic                serial_out_io1_oe_out,
  input wire logic                write_enable_latch_out,
  input wire logic [3:0]          block_protect_field_out,
  input wire logic                status_write_lock_bit_out,
  input wire logic                deep_sleep_out,
  input wire logic                erase_req_out,
  input wire logic                prog_req_out,
  input wire sfcp_pkg::sfcp_req_t req_out,
  input wire logic                cmd_drop_out
);
  // ==========================================================
  // Properties
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);
  sequence s_wel_drop;
    write_enable_latch_out ##1 !write_enable_latch_out;
  endsequence
  // Eight cycles let the pin synchroniser and any decision in flight land.
  sequence s_wp_held;
    (!wp_n_in) [*8];
  endsequence
  property p_oe_idle;
    cs_n_in |-> !serial_out_io1_oe_out && !serial_in_io0_oe_out;
  endproperty
  property p_dual;
    serial_in_io0_oe_out |-> serial_out_io1_oe_out;
  endproperty
  property p_reset;
    disable iff (1'b0)
    srst_in |=> !write_enable_latch_out && !deep_sleep_out &&
      block_protect_field_out == 4'h0 && !erase_req_out && !prog_req_out;
  endproperty
  property p_wel_cycle;
    (erase_req_out || prog_req_out) |-> s_wel_drop;
  endproperty
  property p_drop;
    cmd_drop_out |-> !erase_req_out && !prog_req_out
      ##1 !write_enable_latch_out;
  endproperty
  property p_chip;
    erase_req_out && req_out.kind == sfcp_pkg::ERS_CHIP
      |-> block_protect_field_out == 4'h0;
  endproperty
  property p_map;
    erase_req_out |-> req_out.sector == req_out.addr[20:12] &&
      req_out.half == req_out.addr[20:15] &&
      req_out.block == req_out.addr[20:16];
  endproperty
  property p_sleep;
    deep_sleep_out |-> !erase_req_out && !prog_req_out &&
      $stable(write_enable_latch_out);
  endproperty
  property p_wp;
    s_wp_held |-> $stable(block_protect_field_out) &&
      $stable(status_write_lock_bit_out);
  endproperty
  a_oe_idle: assert property (p_oe_idle)
    else $error("data pin driven while deselected");
  a_dual: assert property (p_dual)
    else $error("io0 driven outside dual read");
  a_reset: assert property (p_reset)
    else $error("state not cleared by reset");
  a_wel_cycle: assert property (p_wel_cycle)
    else $error("write latch not set then cleared around request");
  a_drop: assert property (p_drop)
    else $error("dropped command issued or latch kept");
  a_chip: assert property (p_chip)
    else $error("chip erase with protect field set");
  a_map: assert property (p_map)
    else $error("address split wrong");
  a_sleep: assert property (p_sleep)
    else $error("command acted on in deep sleep");
  a_wp: assert property (p_wp)
    else $error("protect bits changed under write protect pin");
endmodule
bind sfcp_serial_flash_cmd_protect sfcp_props sfcp_props_i (
  .ref_clk_in, .srst_in, .cs_n_in, .wp_n_in, .serial_in_io0_oe_out,
  .serial_out_io1_oe_out, .write_enable_latch_out, .block_protect_field_out,
  .status_write_lock_bit_out, .deep_sleep_out, .erase_req_out,
  .prog_req_out, .req_out, .cmd_drop_out);
`default_nettype wire

//--- bench/sfcp_host_model.sv
/*
  Host serial master model: frames, shifts bits MSB first, captures io1.
  Assumes a free running core clock to align its start to.
*/
`timescale 1ns/100ps
`default_nettype none
module sfcp_host_model (
  input  wire logic ref_clk_in,
  input  wire logic io1_in,
  output logic      sclk_out,
  output logic      cs_n_out,
  output logic      io0_out
);
  // ==========================================================
  // Frame driver
  initial
  begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    io0_out = 1'b0;
  end
  // A released line keeps toggling so a stale value is never read as data.
  always @(posedge ref_clk_in)
  begin
    if (cs_n_out)
      io0_out <= ~io0_out;
  end
  task automatic frame(input logic [47:0] bits, input int n, input int nrd,
                       input logic mode3, output logic [7:0] rd);
    rd = 8'h00;
    @(posedge ref_clk_in);
    #1.3;
    sclk_out = mode3;
    #20;
    cs_n_out = 1'b0;
    #20;
    for (int i = 0; i < n + nrd; i++)
    begin
      if (mode3)
        sclk_out = 1'b0;
      io0_out = (i < n) ? bits[47 - i] : ~io0_out;
      #80;
      sclk_out = 1'b1;
      if (i >= n)
        rd = {rd[6:0], io1_in};
      #80;
      if (!mode3)
        sclk_out = 1'b0;
    end
    #20;
    cs_n_out = 1'b1;
    repeat (12) @(posedge ref_clk_in);
    #1.3;
  endtask
endmodule
`default_nettype wire

//--- bench/testbench.sv
/*
  Self-checking bench for the serial flash command front end.
  Assumes the host model and the bound port checker are compiled with it.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic                ref_clk_in = 1'b0;
  logic                srst_in = 1'b1;
  logic                wp_n = 1'b1;
  logic                busy = 1'b0;
  logic                mode3 = 1'b0;
  logic                saw0 = 1'b0;
  logic                saw1 = 1'b0;
  logic                sclk, cs_n, h_io0, io0_d, io0_oe, io1_d, io1_oe;
  logic                write_enable_latch, deep, er, pg, drop;
  logic [3:0]          bp;
  logic [7:0]          rd;
  sfcp_pkg::sfcp_req_t req, lreq;
  int                  err_total = 0, n_tests = 0, v, b;
  int                  n_er = 0, n_pg = 0, n_dr = 0, x_er = 0, x_pg = 0;
  wire logic           io0_w = io0_oe ? io0_d : h_io0;
  wire logic           io1_w = io1_oe ? io1_d : ~h_io0;
  always #2 ref_clk_in = ~ref_clk_in;
  sfcp_serial_flash_cmd_protect sfcp_serial_flash_cmd_protect_i (
    .ref_clk_in, .srst_in, .clk_en_in(1'b1), .sclk_in(sclk),
    .cs_n_in(cs_n), .serial_in_io0_in(io0_w), .serial_in_io0_out(io0_d),
    .serial_in_io0_oe_out(io0_oe), .serial_out_io1_in(io1_w),
    .serial_out_io1_out(io1_d), .serial_out_io1_oe_out(io1_oe),
    .wp_n_in(wp_n), .busy_in(busy), .write_enable_latch_out(write_enable_latch),
    .block_protect_field_out(bp), .status_write_lock_bit_out(),
    .deep_sleep_out(deep), .erase_req_out(er), .prog_req_out(pg),
    .req_out(req), .cmd_drop_out(drop));
  sfcp_host_model sfcp_host_model_i (.ref_clk_in, .io1_in(io1_w),
    .sclk_out(sclk), .cs_n_out(cs_n), .io0_out(h_io0));
  // ==========================================================
  // Monitors and tasks
  always @(posedge ref_clk_in)
  begin
    n_er += int'(er === 1'b1);
    n_pg += int'(pg === 1'b1);
    n_dr += int'(drop === 1'b1);
    if ((er | pg) === 1'b1)
      lreq = req;
    if (io0_oe === 1'b1)
      saw0 = 1'b1;
    if (io1_oe === 1'b1)
      saw1 = 1'b1;
  end
  task automatic chk(input string what, input logic [23:0] e,
                     input logic [23:0] g);
    n_tests++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic run(input logic [47:0] bits, input int n, input int nrd);
    saw0 = 1'b0;
    saw1 = 1'b0;
    sfcp_host_model_i.frame(bits, n, nrd, mode3, rd);
  endtask
  task automatic set_write_latch_cmd();
    run({8'h06, 40'h0}, 8, 0);
  endtask
  task automatic status_write_cmd(input logic [7:0] d);
    set_write_latch_cmd();
    run({8'h01, d, 32'h0}, 16, 0);
  endtask
  task automatic ev();
    chk("erase count", 24'(x_er), 24'(n_er));
    chk("program count", 24'(x_pg), 24'(n_pg));
  endtask
  function automatic logic exp_prot(input int v, input int b);
    if (v == 0)
      return 1'b0;
    if (v <= 5)
      return b >= 32 - (1 << (v - 1));
    if (v >= 10 && v <= 14)
      return b < 32 - (1 << (14 - v));
    return 1'b1;
  endfunction
  task automatic results();
    $display("Checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ==========================================================
  // Tests
  initial
  begin
    repeat (5) @(posedge ref_clk_in);
    #1.3;
    srst_in = 1'b0;
    repeat (4) @(posedge ref_clk_in);
    #1.3;
    chk("latch", 24'h0, write_enable_latch);
    run({8'h05, 40'h0}, 8, 8);
    chk("status", 24'h00, rd);
    set_write_latch_cmd();
    run({8'h05, 40'h0}, 8, 8);
    chk("status", 24'h02, rd);
    mode3 = 1'b1;
    run({8'h05, 40'h0}, 8, 8);
    chk("status mode 3", 24'h02, rd);
    run({8'h04, 40'h0}, 8, 0);
    mode3 = 1'b0;
    chk("latch", 24'h0, write_enable_latch);
    run({8'h06, 40'h0}, 12, 0);
    chk("latch", 24'h0, write_enable_latch);
    run({8'h77, 40'h0}, 8, 16);
    chk("io1 enable", 24'h0, saw1);
    $display("test framing done");
    run({sfcp_pkg::OP_SECT, 24'h1FF123, 16'h0}, 32, 0);
    ev();
    set_write_latch_cmd();
    run({sfcp_pkg::OP_SECT, 24'h1FF123, 16'h0}, 32, 0);
    x_er++;
    ev();
    chk("map", {9'h1FF, 6'h3F, 5'h1F}, {lreq.sector, lreq.half, lreq.block});
    chk("latch", 24'h0, write_enable_latch);
    set_write_latch_cmd();
    run({sfcp_pkg::OP_SECT, 24'h000000, 16'h0}, 33, 0);
    ev();
    run({sfcp_pkg::OP_PAGE, 24'h000010, 16'hA500}, 40, 0);
    x_pg++;
    ev();
    chk("bytes", 24'h1, lreq.nbytes);
    set_write_latch_cmd();
    run({sfcp_pkg::OP_PAGE, 24'h000010, 16'hA500}, 36, 0);
    ev();
    chk("latch", 24'h1, write_enable_latch);
    run({sfcp_pkg::OP_HALF, 24'h0A8000, 16'h0}, 32, 0);
    x_er++;
    ev();
    chk("half", {2'h1, 6'h15}, {lreq.kind, lreq.half});
    run({sfcp_pkg::OP_DUAL, 24'h0, 16'h0}, 40, 8);
    chk("dual io0 enable", 24'h1, saw0);
    chk("dual data", 24'hFF, rd);
    $display("test commands done");
    for (v = 0; v < 16; v++)
    begin
      b = (v * 3) % 32;
      if (v >= 1 && v <= 5)
        b = 32 - (1 << (v - 1)) - (v & 1);
      if (v >= 10 && v <= 14)
        b = 32 - (1 << (14 - v)) - (v & 1);
      status_write_cmd(8'(v << 2));
      chk("protect field", 24'(v), bp);
      set_write_latch_cmd();
      run({sfcp_pkg::OP_BLK, 24'(b) << 16, 16'h0}, 32, 0);
      x_er += int'(!exp_prot(v, b));
      ev();
      chk("drops", 24'(v + 1 - x_er + 2), 24'(n_dr));
    end
    $display("test protection done");
    set_write_latch_cmd();
    run({sfcp_pkg::OP_CHIP_B, 40'h0}, 8, 0);
    chk("erase count", 24'(x_er), 24'(n_er));
    wp_n = 1'b0;
    status_write_cmd(8'h00);
    chk("protect field", 24'hF, bp);
    wp_n = 1'b1;
    status_write_cmd(8'h00);
    chk("protect field", 24'h0, bp);
    busy = 1'b1;
    set_write_latch_cmd();
    run({sfcp_pkg::OP_SECT, 24'h000000, 16'h0}, 32, 0);
    busy = 1'b0;
    chk("erase count", 24'(x_er), 24'(n_er));
    set_write_latch_cmd();
    run({sfcp_pkg::OP_CHIP_A, 40'h0}, 8, 0);
    x_er++;
    chk("erase count", 24'(x_er), 24'(n_er));
    chk("kind", 24'h3, lreq.kind);
    $display("test locks done");
    run({sfcp_pkg::OP_SLEEP, 40'h0}, 8, 0);
    chk("sleep", 24'h1, deep);
    set_write_latch_cmd();
    chk("latch", 24'h0, write_enable_latch);
    run({sfcp_pkg::OP_SIG, 40'h0}, 8, 0);
    chk("sleep", 24'h0, deep);
    $display("test sleep done");
    results();
  end
  initial
  begin
    #350000;
    err_total++;
    results();
  end
endmodule
`default_nettype wire
